// File: cpt_defs.svh
// Constants for the processor phase sequencer and clock generator
// =============================================================
// Functional notes
// - one phase flop set, steps on ac clock
// - four prep, ten exec phases; repeat, skip
// - prep one, three or four, exec one, ten
// - exec ten end loads next, enters prep one, panel two or io one
// - prep one decodes; format picks next phase
// - prep two up to two clocks; three fetches
// - prep four aligns, up to four clocks
// - exec one follows prep; near done jumps ten
// - panel, trap, io and switch phase flops
// - line start gives pulse; gates may inhibit
// - memory request holds clocks until data release
// - ac clock pulses 40 ns and 50 ns wide
// - selectable intervals 280, 380, 500 ns
// - line two from 180 or 210 ns tap
// - gate restart clock restarts line one
// - crossover keeps fast register clock, no ac clock
// - missing memory clock restarts line, sets trap
// - seven-flop divider gives 1 MHz, 16 kHz
// - 6-bit watchdog restarted at ends, interruptible points
// - watchdog reaching limit starts trap
// - time base 8k/4k/2k/500, external or line
// - rtc trigger decrements count; zero raises level
`ifndef CPT_DEFS_SVH
`define CPT_DEFS_SVH

// =============================================================
// timing
`define CPT_CLK_MHZ 125
`define CPT_UP(ns) ((((ns) * `CPT_CLK_MHZ) + 999) / 1000)
`define CPT_NARROW_NS 40
`define CPT_WIDE_NS 50
`define CPT_SHORT_NS 280
`define CPT_MEDIUM_NS 380
`define CPT_LONG_NS 500
`define CPT_TAP_CLR_NS 180
`define CPT_TAP_SET_NS 210
`define CPT_MISS_NS 2000
`define CPT_NARROW_CYC `CPT_UP(`CPT_NARROW_NS)
`define CPT_WIDE_CYC `CPT_UP(`CPT_WIDE_NS)
`define CPT_SHORT_CYC `CPT_UP(`CPT_SHORT_NS)
`define CPT_MEDIUM_CYC `CPT_UP(`CPT_MEDIUM_NS)
`define CPT_LONG_CYC `CPT_UP(`CPT_LONG_NS)
`define CPT_TAP_CLR_CYC `CPT_UP(`CPT_TAP_CLR_NS)
`define CPT_TAP_SET_CYC `CPT_UP(`CPT_TAP_SET_NS)
`define CPT_WDOG_TRIP 6'h2a
`define CPT_EA_W 17
`define CPT_FAST_TOP 17'h0000f

// =============================================================
// registers
`define CPT_A_CTRL 12'h000
`define CPT_A_STAT 12'h004
`define CPT_A_RTC 12'h008
`define CPT_F_IVL 1:0
`define CPT_F_TB 4:2
`define CPT_F_RUN 5
`define CPT_F_PHASE 4:0
`define CPT_F_TRAP 8
`define CPT_F_ZERO 9
`define CPT_F_WAIT 10
`define CPT_F_WDOG 21:16
`define CPT_F_RTC 15:0
`define CPT_IVL_RST 2'h1
`define CPT_TB_RST 3'h0
`define CPT_TB_8K 3'h0
`define CPT_TB_4K 3'h1
`define CPT_TB_2K 3'h2
`define CPT_TB_500 3'h3
`define CPT_TB_EXT 3'h4
`define CPT_TB_LINE 3'h5

`endif

// File: cpt_pkg.sv
// Types shared by the phase sequencer and its bench
package cpt_pkg;

   typedef enum logic [4:0] {
      prep_phase_one, prep_phase_two, prep_phase_three, prep_phase_four,
      exec_phase_one, exec_phase_two, exec_phase_three, exec_phase_four,
      exec_phase_five, exec_phase_six, exec_phase_seven, exec_phase_eight,
      exec_phase_nine, exec_phase_ten,
      panel_phase_first, panel_phase_two, panel_phase_three,
      panel_phase_four, panel_phase_five, panel_phase_last,
      interrupt_trap_phase_first, interrupt_trap_phase_second,
      io_phase_first, io_phase_two, io_phase_three, io_phase_last
   } cpt_phase_e;

   typedef enum logic {gen_run, gen_wait} cpt_gen_e;

   typedef struct packed {
      logic idx_req;
      logic ind_req;
      logic opnd_fetch;
      logic align_req;
      logic [1:0] align_clks;
      logic near_done;
      logic exec_hold;
      logic interruptible;
      logic panel_idle;
      logic io_req;
   } cpt_instr_s;

endpackage

// File: cpt_clocks.sv
// Processor phase sequencer, delay-line clock generator, watchdog and time base
`timescale 1ns/1ps
`include "cpt_defs.svh"

module cpt_clocks import cpt_pkg::*; #(
   parameter int MISS_NS = `CPT_MISS_NS
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic [11:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire cpt_instr_s INSTR_CTRL,
   input wire logic [`CPT_EA_W-1:0] EFF_ADDR,
   input wire logic DATA_RELEASE,
   input wire logic OSC_2MHZ,
   input wire logic EXT_TIMEBASE,
   input wire logic LINE_60HZ,
   output logic AC_CLOCK_NARROW,
   output logic AC_CLOCK_WIDE,
   output logic FAST_REG_CLOCK,
   output logic [25:0] PHASE,
   output logic [15:0] SWITCH_PHASE,
   output logic MEM_REQUEST,
   output logic LOAD_NEXT,
   output logic TRAP,
   output logic CLOCK_1MHZ,
   output logic CLOCK_16KHZ,
   output logic RTC_TRIGGER,
   output logic COUNT_ZERO
);

   localparam int MISS_CYC = (MISS_NS * `CPT_CLK_MHZ) / 1000;

   generate
      if (MISS_CYC < 1 || MISS_CYC > 4095) begin : g_bad_miss
         $error("MISS_NS gives a wait count outside 1..4095");
      end
   endgenerate

   localparam logic [6:0] narrow_c = 7'(`CPT_NARROW_CYC);
   localparam logic [6:0] wide_c = 7'(`CPT_WIDE_CYC);
   localparam logic [6:0] interval_short = 7'(`CPT_SHORT_CYC - 1);
   localparam logic [6:0] interval_medium = 7'(`CPT_MEDIUM_CYC - 1);
   localparam logic [6:0] interval_long = 7'(`CPT_LONG_CYC - 1);
   localparam logic [6:0] tap_clr_c = 7'(`CPT_TAP_CLR_CYC);
   localparam logic [6:0] tap_set_c = 7'(`CPT_TAP_SET_CYC);
   localparam logic [11:0] miss_last_c = 12'(MISS_CYC - 1);

   // =============================================================
   // input synchronisers: release, oscillator, external, line
   logic [3:0] s1_ff, s2_ff, s3_ff;
   logic [3:0] rise;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         s1_ff <= 4'h0;
         s2_ff <= 4'h0;
         s3_ff <= 4'h0;
      end else begin
         s1_ff <= {LINE_60HZ, EXT_TIMEBASE, OSC_2MHZ, DATA_RELEASE};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   assign rise = s2_ff & ~s3_ff;

   // =============================================================
   // control register
   logic [1:0] ivl_ff;
   logic [2:0] tb_sel_ff;
   logic run_ff;
   logic setup, wr_acc;

   assign setup = PSEL && !PENABLE;
   // a write lands only in the access cycle, which is the one with ready high
   assign wr_acc = PSEL && PENABLE && PWRITE && PREADY;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ivl_ff <= `CPT_IVL_RST;
         tb_sel_ff <= `CPT_TB_RST;
         run_ff <= 1'b1;
      end else if (wr_acc && PADDR == `CPT_A_CTRL) begin
         ivl_ff <= PWDATA[`CPT_F_IVL];
         tb_sel_ff <= PWDATA[`CPT_F_TB];
         run_ff <= PWDATA[`CPT_F_RUN];
      end
   end

   // =============================================================
   // delay line clock generator
   cpt_gen_e gen_ff;
   logic [6:0] cnt_ff;
   logic [11:0] miss_ff;
   logic gate_ff, xover_ff, mem_req_ff;
   logic [6:0] end_cnt, tap;
   logic gate_restart_clock, missing_memory_clock, start, adv;
   logic issue, fast;

   always_comb begin
      unique case (ivl_ff)
         2'h0: end_cnt = interval_short;
         2'h1: end_cnt = interval_medium;
         default: end_cnt = interval_long;
      endcase
   end

   assign tap = mem_req_ff ? tap_set_c : tap_clr_c;
   // at or past the end, so a shorter interval written mid-cycle cannot wrap the count
   assign gate_restart_clock = gen_ff == gen_run && cnt_ff >= end_cnt;
   assign missing_memory_clock = gen_ff == gen_wait && mem_req_ff
      && miss_ff == miss_last_c;
   // line one stays inhibited while memory owes data
   assign start = run_ff && ((gate_restart_clock && !mem_req_ff)
      || (gen_ff == gen_wait && (!mem_req_ff || missing_memory_clock)));
   // phases step in the last cycle of the narrow ac clock, one cycle before its trailing edge
   assign adv = gen_ff == gen_run && gate_ff && cnt_ff == narrow_c - 7'h1;
   assign fast = EFF_ADDR <= `CPT_FAST_TOP;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         gen_ff <= gen_wait;
         cnt_ff <= 7'h0;
      end else if (start) begin
         gen_ff <= gen_run;
         cnt_ff <= 7'h0;
      end else if (gate_restart_clock) begin
         gen_ff <= gen_wait;
      end else if (gen_ff == gen_run) begin
         cnt_ff <= cnt_ff + 7'h1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         gate_ff <= 1'b0;
      end else if (start) begin
         gate_ff <= !xover_ff;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         miss_ff <= 12'h0;
      end else if (gen_ff == gen_wait && mem_req_ff && !missing_memory_clock) begin
         miss_ff <= miss_ff + 12'h1;
      end else begin
         miss_ff <= 12'h0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         mem_req_ff <= 1'b0;
      end else if (issue) begin
         mem_req_ff <= 1'b1;
      end else if (rise[0] || missing_memory_clock) begin
         mem_req_ff <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         AC_CLOCK_NARROW <= 1'b0;
         AC_CLOCK_WIDE <= 1'b0;
         FAST_REG_CLOCK <= 1'b0;
      end else begin
         AC_CLOCK_NARROW <= gen_ff == gen_run && gate_ff && cnt_ff < narrow_c;
         AC_CLOCK_WIDE <= gen_ff == gen_run && gate_ff && cnt_ff < wide_c;
         // the fast register clock ignores the ac gate, so crossover still reaches it
         FAST_REG_CLOCK <= gen_ff == gen_run && cnt_ff >= tap
            && cnt_ff < tap + narrow_c;
      end
   end

   // =============================================================
   // phase sequencer
   cpt_phase_e state_ff, nxt_state;
   logic [1:0] hold_ff, nxt_hold;
   logic trap_pend_ff;
   logic load;

   always_comb begin
      nxt_state = state_ff;
      nxt_hold = hold_ff;
      load = 1'b0;
      if (adv) begin
         if (trap_pend_ff && state_ff != interrupt_trap_phase_first
               && state_ff != interrupt_trap_phase_second) begin
            nxt_state = interrupt_trap_phase_first;
            nxt_hold = 2'h0;
         end else begin
            unique case (state_ff)
               prep_phase_one: begin
                  if (INSTR_CTRL.idx_req || INSTR_CTRL.ind_req) begin
                     nxt_state = prep_phase_two;
                  end else if (INSTR_CTRL.opnd_fetch) begin
                     nxt_state = prep_phase_three;
                  end else begin
                     nxt_state = prep_phase_four;
                  end
                  nxt_hold = 2'h0;
               end
               prep_phase_two: begin
                  // indirect plus index needs the second clock time
                  if (INSTR_CTRL.idx_req && INSTR_CTRL.ind_req && hold_ff == 2'h0) begin
                     nxt_hold = 2'h1;
                  end else begin
                     nxt_state = prep_phase_three;
                     nxt_hold = 2'h0;
                  end
               end
               prep_phase_three: begin
                  nxt_state = INSTR_CTRL.align_req ? prep_phase_four : exec_phase_one;
               end
               prep_phase_four: begin
                  if (hold_ff < INSTR_CTRL.align_clks) begin
                     nxt_hold = hold_ff + 2'h1;
                  end else begin
                     nxt_state = exec_phase_one;
                     nxt_hold = 2'h0;
                  end
               end
               exec_phase_one, exec_phase_two, exec_phase_three, exec_phase_four,
               exec_phase_five, exec_phase_six, exec_phase_seven,
               exec_phase_eight, exec_phase_nine: begin
                  if (INSTR_CTRL.near_done) begin
                     nxt_state = exec_phase_ten;
                  end else if (!INSTR_CTRL.exec_hold) begin
                     nxt_state = cpt_phase_e'(state_ff + 5'h1);
                  end
               end
               exec_phase_ten: begin
                  load = 1'b1;
                  if (INSTR_CTRL.panel_idle) begin
                     nxt_state = panel_phase_two;
                  end else if (INSTR_CTRL.io_req) begin
                     nxt_state = io_phase_first;
                  end else begin
                     nxt_state = prep_phase_one;
                  end
               end
               panel_phase_first, panel_phase_four, panel_phase_five,
               panel_phase_last: nxt_state = prep_phase_one;
               panel_phase_two: begin
                  if (!INSTR_CTRL.panel_idle) begin
                     nxt_state = panel_phase_three;
                  end
               end
               panel_phase_three: nxt_state = exec_phase_ten;
               interrupt_trap_phase_first: nxt_state = interrupt_trap_phase_second;
               interrupt_trap_phase_second: nxt_state = prep_phase_one;
               io_phase_first: nxt_state = io_phase_two;
               io_phase_two: begin
                  if (SWITCH_PHASE[15]) begin
                     nxt_state = io_phase_three;
                  end
               end
               io_phase_three: nxt_state = io_phase_last;
               io_phase_last: nxt_state = prep_phase_one;
            endcase
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_ff <= exec_phase_ten;
         hold_ff <= 2'h0;
         PHASE <= 26'h1 << exec_phase_ten;
      end else begin
         state_ff <= nxt_state;
         hold_ff <= nxt_hold;
         PHASE <= 26'h1 << nxt_state;
      end
   end

   // switch phases move on the same edge as the io phase, never a cycle behind
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         SWITCH_PHASE <= 16'h0;
      end else if (nxt_state != io_phase_two) begin
         SWITCH_PHASE <= 16'h0;
      end else if (state_ff != io_phase_two) begin
         SWITCH_PHASE <= 16'h0001;
      end else if (adv) begin
         SWITCH_PHASE <= {SWITCH_PHASE[14:0], 1'b0};
      end
   end

   // instruction fetch on exec ten, operand fetch into prep three outside crossover
   assign issue = adv && (load || (nxt_state == prep_phase_three
      && state_ff != prep_phase_three && !fast));

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         xover_ff <= 1'b0;
      end else if (adv && nxt_state == prep_phase_three
            && state_ff != prep_phase_three && fast) begin
         xover_ff <= 1'b1;
      end else if (start) begin
         xover_ff <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         LOAD_NEXT <= 1'b0;
         MEM_REQUEST <= 1'b0;
      end else begin
         LOAD_NEXT <= load;
         MEM_REQUEST <= issue || (mem_req_ff && !rise[0] && !missing_memory_clock);
      end
   end

   // =============================================================
   // oscillator divider and watchdog
   logic [6:0] div_ff;
   logic [5:0] wd_ff;
   logic tick_1m, tick_16k, wd_restart, wd_trip;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         div_ff <= 7'h0;
      end else if (rise[1]) begin
         div_ff <= div_ff + 7'h1;
      end
   end

   assign tick_1m = rise[1] && div_ff[0];
   assign tick_16k = rise[1] && &div_ff;
   assign wd_restart = load || (adv && INSTR_CTRL.interruptible);
   assign wd_trip = tick_1m && !wd_restart && wd_ff == `CPT_WDOG_TRIP - 6'h1;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         wd_ff <= 6'h0;
      end else if (wd_restart) begin
         wd_ff <= 6'h0;
      end else if (tick_1m && wd_ff != `CPT_WDOG_TRIP) begin
         wd_ff <= wd_ff + 6'h1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         CLOCK_1MHZ <= 1'b0;
         CLOCK_16KHZ <= 1'b0;
      end else begin
         CLOCK_1MHZ <= div_ff[0];
         CLOCK_16KHZ <= div_ff[6];
      end
   end

   // =============================================================
   // trap state; a new trap beats a software clear in the same cycle
   logic trap_set;

   assign trap_set = wd_trip || missing_memory_clock;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         trap_pend_ff <= 1'b0;
      end else if (trap_set) begin
         trap_pend_ff <= 1'b1;
      end else if (adv && nxt_state == interrupt_trap_phase_first) begin
         trap_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         TRAP <= 1'b0;
      end else if (trap_set) begin
         TRAP <= 1'b1;
      end else if (wr_acc && PADDR == `CPT_A_STAT && PWDATA[`CPT_F_TRAP]) begin
         TRAP <= 1'b0;
      end
   end

   // =============================================================
   // time base selector and real-time count
   logic [4:0] tb_cnt_ff;
   logic [15:0] rtc_ff;
   logic zero_stat_ff, tb_tick, zero_ev, rtc_wr;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         tb_cnt_ff <= 5'h0;
      end else if (tick_16k) begin
         tb_cnt_ff <= tb_cnt_ff + 5'h1;
      end
   end

   always_comb begin
      unique case (tb_sel_ff)
         `CPT_TB_8K: tb_tick = tick_16k && tb_cnt_ff[0];
         `CPT_TB_4K: tb_tick = tick_16k && &tb_cnt_ff[1:0];
         `CPT_TB_2K: tb_tick = tick_16k && &tb_cnt_ff[2:0];
         `CPT_TB_500: tb_tick = tick_16k && &tb_cnt_ff;
         `CPT_TB_EXT: tb_tick = rise[2];
         `CPT_TB_LINE: tb_tick = rise[3];
         default: tb_tick = 1'b0;
      endcase
   end

   assign rtc_wr = wr_acc && PADDR == `CPT_A_RTC;
   assign zero_ev = tb_tick && !rtc_wr && rtc_ff == 16'h0001;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rtc_ff <= 16'h0;
      end else if (rtc_wr) begin
         rtc_ff <= PWDATA[`CPT_F_RTC];
      end else if (tb_tick && rtc_ff != 16'h0) begin
         rtc_ff <= rtc_ff - 16'h1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         zero_stat_ff <= 1'b0;
      end else if (zero_ev) begin
         zero_stat_ff <= 1'b1;
      end else if (wr_acc && PADDR == `CPT_A_STAT && PWDATA[`CPT_F_ZERO]) begin
         zero_stat_ff <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         RTC_TRIGGER <= 1'b0;
         COUNT_ZERO <= 1'b0;
      end else begin
         RTC_TRIGGER <= tb_tick;
         COUNT_ZERO <= zero_ev;
      end
   end

   // =============================================================
   // apb read side: data captured in setup, answered next cycle
   logic [31:0] rd_data;
   logic mapped;

   always_comb begin
      rd_data = 32'h0;
      mapped = 1'b1;
      unique case (PADDR)
         `CPT_A_CTRL: begin
            rd_data[`CPT_F_IVL] = ivl_ff;
            rd_data[`CPT_F_TB] = tb_sel_ff;
            rd_data[`CPT_F_RUN] = run_ff;
         end
         `CPT_A_STAT: begin
            rd_data[`CPT_F_PHASE] = state_ff;
            rd_data[`CPT_F_TRAP] = TRAP;
            rd_data[`CPT_F_ZERO] = zero_stat_ff;
            rd_data[`CPT_F_WAIT] = mem_req_ff;
            rd_data[`CPT_F_WDOG] = wd_ff;
         end
         `CPT_A_RTC: rd_data[`CPT_F_RTC] = rtc_ff;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && !mapped;
         PRDATA <= (setup && !PWRITE) ? rd_data : 32'h0;
      end
   end

endmodule

// File: cpt_clocks_chk.sv
// concurrent checks on the phase sequencer ports
`timescale 1ns/1ps
module cpt_clocks_chk (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic AC_CLOCK_NARROW,
   input wire logic AC_CLOCK_WIDE,
   input wire logic [25:0] PHASE,
   input wire logic [15:0] SWITCH_PHASE,
   input wire logic MEM_REQUEST,
   input wire logic LOAD_NEXT
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);
   // ====================================
   // pulse shapes
   sequence s_narrow;
      AC_CLOCK_NARROW [*5] ##1 !AC_CLOCK_NARROW;
   endsequence
   sequence s_wide;
      AC_CLOCK_WIDE [*7] ##1 !AC_CLOCK_WIDE;
   endsequence
   property p_narrow;
      $rose(AC_CLOCK_NARROW) |-> s_narrow;
   endproperty
   a_narrow: assert property (p_narrow) else $error("narrow pulse width");
   property p_wide;
      $rose(AC_CLOCK_NARROW) |-> $rose(AC_CLOCK_WIDE) ##0 s_wide;
   endproperty
   a_wide: assert property (p_wide) else $error("wide pulse width");
   // ====================================
   // phases
   property p_onehot;
      $onehot(PHASE);
   endproperty
   a_onehot: assert property (p_onehot) else $error("phase not one-hot");
   property p_load;
      LOAD_NEXT |-> (PHASE[0] || PHASE[15] || PHASE[22]);
   endproperty
   a_load: assert property (p_load) else $error("load without prep one");
   property p_prep1;
      $fell(PHASE[0]) |-> (PHASE[1] || PHASE[2] || PHASE[3] || PHASE[20]);
   endproperty
   a_prep1: assert property (p_prep1) else $error("bad phase after prep one");
   property p_sw;
      (SWITCH_PHASE != 16'h0) |-> PHASE[23] && $onehot(SWITCH_PHASE);
   endproperty
   a_sw: assert property (p_sw) else $error("switch phase outside io");
   // a held request must block every new clock cycle
   property p_hold;
      MEM_REQUEST && $past(MEM_REQUEST) |-> !$rose(AC_CLOCK_NARROW);
   endproperty
   a_hold: assert property (p_hold) else $error("clock during memory wait");
   // ====================================
   // register bus
   property p_apb;
      PSEL && !PENABLE |=> PREADY ##1 !PREADY;
   endproperty
   a_apb: assert property (p_apb) else $error("ready timing");
   property p_err;
      PSLVERR |-> PREADY && (PRDATA == 32'h0);
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
endmodule

// File: cpt_mem_model.sv
// core memory stand-in: answers a request with a data release after a delay
`timescale 1ns/1ps
module cpt_mem_model (
   input wire logic clk,
   input wire logic mem_request,
   input wire logic miss,
   output logic data_release
);
   initial data_release = 1'b0;
   // a missing bank never answers, leaving the timeout to recover
   always @(posedge clk) begin
      if (!mem_request) begin
         data_release <= 1'b0;
      end else if (!miss && !data_release) begin
         repeat ($urandom_range(6, 1)) @(posedge clk);
         data_release <= 1'b1;
      end
   end
endmodule

// File: cpt_clocks_tb.sv
// self-checking bench for the phase sequencer
`timescale 1ns/1ps
`define CMP(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module cpt_clocks_tb import cpt_pkg::*; ;
   logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, osc = 1'b0, ext = 1'b0, line = 1'b0, miss = 1'b0, rel;
   cpt_instr_s ictl = '0;
   logic [16:0] eaddr = 17'h100;
   logic narrow, wide, fclk, mreq, loadn, trap, c1m, c16k, rtct, czero;
   logic [25:0] phase;
   logic [15:0] swp, r;
   logic [33:0] notes[$], nt;
   int n_fail = 0, n_tests = 0, ac_n = 0, f_n = 0, z_n = 0, a0, f0, k;
   longint t0;
   int ivns[4] = '{280, 380, 500, 500};
   always #4 mclk = ~mclk;
   always #250 osc = ~osc;
   always @(posedge narrow) ac_n++;
   always @(posedge fclk) f_n++;
   always @(posedge czero) z_n++;
   cpt_clocks #(.MISS_NS(80)) u_cpt_clocks (.MCLK(mclk), .RESET(reset), .PADDR(paddr),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .INSTR_CTRL(ictl), .EFF_ADDR(eaddr),
      .DATA_RELEASE(rel), .OSC_2MHZ(osc), .EXT_TIMEBASE(ext), .LINE_60HZ(line),
      .AC_CLOCK_NARROW(narrow), .AC_CLOCK_WIDE(wide), .FAST_REG_CLOCK(fclk),
      .PHASE(phase), .SWITCH_PHASE(swp), .MEM_REQUEST(mreq), .LOAD_NEXT(loadn),
      .TRAP(trap), .CLOCK_1MHZ(c1m), .CLOCK_16KHZ(c16k), .RTC_TRIGGER(rtct),
      .COUNT_ZERO(czero));
   cpt_mem_model u_cpt_mem_model (.clk(mclk), .mem_request(mreq), .miss(miss),
      .data_release(rel));
   // ====================================
   // bus tasks; note = {check data, expected error, expected data}
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [33:0] note);
      @(posedge mclk);
      notes.push_back(note);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge mclk) begin
      if (pready === 1'b1 && psel && penable) begin
         nt = notes.pop_front();
         `CMP(pslverr, nt[32])
         if (nt[33]) `CMP(prdata, nt[31:0])
      end
   end
   task automatic await_rise;
      int n;
      n = ac_n;
      for (int i = 0; i < 300 && n == ac_n; i++) @(posedge mclk);
   endtask
   task automatic next_phase(input int e);
      logic [25:0] p;
      p = phase;
      for (int i = 0; i < 2000 && phase === p; i++) @(posedge mclk);
      `CMP(phase, 26'h1 << e)
   endtask
   task automatic pulse(input logic w);
      @(posedge mclk);
      ext <= w;
      line <= !w;
      repeat (4) @(posedge mclk);
      ext <= 1'b0;
      line <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ====================================
   // scenarios
   initial begin
      void'($urandom(32'h962bd06f));
      ictl.exec_hold <= 1'b1;
      ictl.interruptible <= 1'b1;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      apb(0, 12'h000, 0, {2'b10, 32'h21});
      apb(0, 12'h00c, 0, {2'b11, 32'h0});
      apb(1, 12'h01c, $urandom, {2'b01, 32'h0});
      for (int i = 0; i < 4; i++) begin
         apb(1, 12'h000, 32'h20 | i, 34'h0);
         await_rise();
         await_rise();
         t0 = $time;
         await_rise();
         `CMP(($time - t0) / 8, (ivns[i] + 7) / 8)
      end
      ictl <= '{opnd_fetch: 1'b1, align_req: 1'b1, align_clks: 2'h2, near_done: 1'b1,
         interruptible: 1'b1, default: 1'b0};
      eaddr <= 17'($urandom_range(15, 0));
      for (k = 0; k < 3000 && phase !== 26'h2000; k++) @(posedge mclk);
      next_phase(0);
      next_phase(2);
      // crossover into prep three drops the ac clock for one generator cycle
      a0 = ac_n;
      f0 = f_n;
      t0 = $time;
      next_phase(3);
      `CMP(ac_n - a0, 1)
      `CMP(f_n - f0, 2)
      `CMP(($time - t0) / 8, 2 * 63)
      t0 = $time;
      next_phase(4);
      `CMP(($time - t0) / 8, 3 * 63)
      next_phase(13);
      next_phase(0);
      miss <= 1'b1;
      for (k = 0; k < 3000 && trap !== 1'b1; k++) @(posedge mclk);
      `CMP(trap, 1'b1)
      miss <= 1'b0;
      apb(0, 12'h004, 0, 34'h0);
      `CMP(rd[8], 1'b1)
      apb(1, 12'h004, 32'h100, 34'h0);
      apb(0, 12'h004, 0, 34'h0);
      `CMP(rd[8], 1'b0)
      // stopping the generator removes every watchdog restart
      apb(1, 12'h000, 32'h3, 34'h0);
      repeat (4700) @(posedge mclk);
      `CMP(trap, 1'b0)
      for (k = 0; k < 1500 && trap !== 1'b1; k++) @(posedge mclk);
      `CMP(trap, 1'b1)
      apb(1, 12'h000, 32'h31, 34'h0);
      apb(1, 12'h008, 32'h2, 34'h0);
      pulse(1);
      pulse(1);
      pulse(1);
      apb(0, 12'h008, 0, {2'b10, 32'h0});
      apb(0, 12'h004, 0, 34'h0);
      `CMP(rd[9], 1'b1)
      `CMP(z_n, 1)
      r = 16'($urandom_range(16'hffff, 2));
      apb(1, 12'h008, {16'($urandom), r}, 34'h0);
      apb(1, 12'h000, 32'h35, 34'h0);
      pulse(1);
      pulse(0);
      apb(0, 12'h008, 0, {2'b10, 16'h0, r - 16'h1});
      ictl.io_req <= 1'b1;
      for (k = 0; k < 3000 && phase !== 26'h400000; k++) @(posedge mclk);
      next_phase(23);
      t0 = $time;
      `CMP(swp, 16'h1)
      next_phase(24);
      `CMP(($time - t0) / 8, 16 * 48)
      conclude();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      n_fail++;
      conclude();
   end
endmodule
bind cpt_clocks cpt_clocks_chk u_cpt_clocks_chk (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .AC_CLOCK_NARROW(AC_CLOCK_NARROW), .AC_CLOCK_WIDE(AC_CLOCK_WIDE), .PHASE(PHASE),
   .SWITCH_PHASE(SWITCH_PHASE), .MEM_REQUEST(MEM_REQUEST), .LOAD_NEXT(LOAD_NEXT));
